// ===== rtcpt_pkg.sv
// Function
// R1 - Count value split into two byte registers
// R2 - Count write lands two slow ticks later
// R3 - Top value byte pair, resets all ones
// R4 - Top write lands two slow ticks later
// R5 - Match value byte pair, resets to zero
// R6 - Tick interval code selects power-of-two spacing
// R7 - Control bit 0 switches tick timer on
// R8 - Status bit 0 shows control sync pending
// R9 - Enable bit 0 gates tick interrupt
// R10 - Tick sets flag, write one clears
// R11 - Debug bit chooses halt or run
// R12 - Count reaching top wraps, sets flag
// R13 - Count equal match sets match flag
// R14 - Source select picks slow clock origin
// R15 - Shared byte latch gives atomic 16-bit access
// R16 - Counter advances per prescaled slow tick
package rtcpt_pkg;

  // Register indices; the APB byte address is four times the index.
  localparam logic [5:0] IDX_CTRL      = 6'h00;
  localparam logic [5:0] IDX_STATUS    = 6'h01;
  localparam logic [5:0] IDX_INTEN     = 6'h02;
  localparam logic [5:0] IDX_INTFLAG   = 6'h03;
  localparam logic [5:0] IDX_TEMP      = 6'h04;
  localparam logic [5:0] IDX_DBG       = 6'h05;
  localparam logic [5:0] IDX_SRC_SEL   = 6'h07;
  localparam logic [5:0] IDX_COUNT_L   = 6'h08;
  localparam logic [5:0] IDX_COUNT_H   = 6'h09;
  localparam logic [5:0] IDX_TOP_L     = 6'h0A;
  localparam logic [5:0] IDX_TOP_H     = 6'h0B;
  localparam logic [5:0] IDX_MATCH_L   = 6'h0C;
  localparam logic [5:0] IDX_MATCH_H   = 6'h0D;
  localparam logic [5:0] IDX_PIT_CTRL  = 6'h10;
  localparam logic [5:0] IDX_PIT_STAT  = 6'h11;
  localparam logic [5:0] IDX_PIT_IRQEN = 6'h12;
  localparam logic [5:0] IDX_PIT_FLAG  = 6'h13;
  localparam logic [5:0] IDX_PIT_DBG   = 6'h15;

  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] TOP_RST   = 16'hFFFF;
  localparam logic [15:0] MATCH_RST = 16'h0000;
  localparam logic [7:0]  BYTE_RST  = 8'h00;

  // Slow-clock cycles from a write until it takes effect.
  localparam logic [1:0] SYNC_TICKS = 2'h2;
  // The 1.024 kHz source is the 32.768 kHz source divided by 32.
  localparam logic [4:0] DIV_1K_LAST = 5'h1F;

  localparam logic [3:0] PIT_CODE_OFF  = 4'h0;
  localparam logic [3:0] PIT_CODE_RSVD = 4'hF;

  localparam int FLAG_WRAP  = 0;
  localparam int FLAG_MATCH = 1;

  typedef enum logic [1:0] {
    SRC_32K  = 2'b00,
    SRC_1K   = 2'b01,
    SRC_RSVD = 2'b10,
    SRC_EXT  = 2'b11
  } rtcpt_src_t;

  // Byte layout: bits 6:3 code, bit 0 on.
  typedef struct packed {
    logic [3:0] code;
    logic       on;
  } rtcpt_ctrl_t;

  localparam rtcpt_ctrl_t CTRL_RST = '{code: 4'h0, on: 1'b0};

endpackage

// ===== rtcpt_top.sv
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps

module rtcpt_sync_delay (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic start,
  input  wire logic slow_tick,
  output logic      busy,
  output logic      apply
);

  logic [1:0] left_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) left_q <= 2'h0;
    else if (start) left_q <= rtcpt_pkg::SYNC_TICKS;
    else if (slow_tick && (left_q != 2'h0)) left_q <= left_q - 2'h1;
  end

  assign busy  = (left_q != 2'h0);
  assign apply = slow_tick && (left_q == 2'h1) && !start;

endmodule

module rtcpt_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        osc32k_in,
  input  wire logic        ext_clk_in,
  input  wire logic        cpu_debug_halt,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic [5:0]  idx;
  logic        mapped;
  logic        acc;
  logic        wr;
  logic        rd;
  logic [7:0]  wbyte;
  logic [7:0]  rd_val;

  assign idx   = paddr[7:2];
  assign acc   = psel && penable && mapped;
  assign wr    = acc && pwrite && pstrb[0];
  // The latch is filled in the setup cycle, with the low byte, so a carry cannot split them.
  assign rd    = psel && !penable && !pwrite;
  assign wbyte = pwdata[7:0];

  always_comb begin
    case (idx)
      rtcpt_pkg::IDX_CTRL, rtcpt_pkg::IDX_STATUS, rtcpt_pkg::IDX_INTEN,
      rtcpt_pkg::IDX_INTFLAG, rtcpt_pkg::IDX_TEMP, rtcpt_pkg::IDX_DBG,
      rtcpt_pkg::IDX_SRC_SEL, rtcpt_pkg::IDX_COUNT_L, rtcpt_pkg::IDX_COUNT_H,
      rtcpt_pkg::IDX_TOP_L, rtcpt_pkg::IDX_TOP_H, rtcpt_pkg::IDX_MATCH_L,
      rtcpt_pkg::IDX_MATCH_H, rtcpt_pkg::IDX_PIT_CTRL, rtcpt_pkg::IDX_PIT_STAT,
      rtcpt_pkg::IDX_PIT_IRQEN, rtcpt_pkg::IDX_PIT_FLAG,
      rtcpt_pkg::IDX_PIT_DBG: mapped = 1'b1;
      default:                mapped = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  rtcpt_pkg::rtcpt_ctrl_t ctrl_sw_q;
  rtcpt_pkg::rtcpt_ctrl_t ctrl_act_q;
  rtcpt_pkg::rtcpt_ctrl_t pit_sw_q;
  rtcpt_pkg::rtcpt_ctrl_t pit_act_q;
  rtcpt_pkg::rtcpt_src_t  slow_clock_source_q;
  logic        keep_running_when_halted_q;
  logic        pit_keep_running_q;
  logic [1:0]  inten_q;
  logic [1:0]  flags_q;
  logic        tick_irq_en_q;
  logic        tick_irq_q;
  logic [7:0]  temp_q;
  logic [15:0] count_value_q;
  logic [15:0] count_pend_q;
  logic [15:0] top_sw_q;
  logic [15:0] top_act_q;
  logic [15:0] match_sw_q;
  logic [15:0] match_act_q;
  logic [31:0] prdata_q;
  logic ctrl_busy;
  logic ctrl_apply;
  logic count_sync_pending;
  logic count_apply;
  logic top_sync_pending;
  logic top_apply;
  logic match_busy;
  logic match_apply;
  logic tick_ctrl_sync_pending;
  logic pit_apply;
  logic wr_ctrl;
  logic wr_count_h;
  logic wr_top_h;
  logic wr_match_h;
  logic wr_pit;

  assign wr_ctrl    = wr && (idx == rtcpt_pkg::IDX_CTRL);
  assign wr_count_h = wr && (idx == rtcpt_pkg::IDX_COUNT_H);
  assign wr_top_h   = wr && (idx == rtcpt_pkg::IDX_TOP_H);
  assign wr_match_h = wr && (idx == rtcpt_pkg::IDX_MATCH_H);
  assign wr_pit     = wr && (idx == rtcpt_pkg::IDX_PIT_CTRL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_sw_q                  <= rtcpt_pkg::CTRL_RST;
      pit_sw_q                   <= rtcpt_pkg::CTRL_RST;
      slow_clock_source_q        <= rtcpt_pkg::SRC_32K;
      keep_running_when_halted_q <= 1'b0;
      pit_keep_running_q         <= 1'b0;
      inten_q                    <= 2'h0;
      tick_irq_en_q              <= 1'b0;
    end else if (wr) begin
      case (idx)
        rtcpt_pkg::IDX_CTRL:      ctrl_sw_q <= '{code: wbyte[6:3], on: wbyte[0]};
        // R7 tick timer switch
        rtcpt_pkg::IDX_PIT_CTRL:  pit_sw_q <= '{code: wbyte[6:3], on: wbyte[0]};
        // R14 source select
        rtcpt_pkg::IDX_SRC_SEL:   slow_clock_source_q <= rtcpt_pkg::rtcpt_src_t'(wbyte[1:0]);
        rtcpt_pkg::IDX_DBG:       keep_running_when_halted_q <= wbyte[0];
        rtcpt_pkg::IDX_PIT_DBG:   pit_keep_running_q <= wbyte[0];
        rtcpt_pkg::IDX_INTEN:     inten_q <= wbyte[1:0];
        rtcpt_pkg::IDX_PIT_IRQEN: tick_irq_en_q <= wbyte[0];
        default: ;
      endcase
    end
  end

  // R15 shared byte latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_q <= rtcpt_pkg::BYTE_RST;
    end else if (wr && ((idx == rtcpt_pkg::IDX_TEMP) || (idx == rtcpt_pkg::IDX_COUNT_L) ||
                        (idx == rtcpt_pkg::IDX_TOP_L) || (idx == rtcpt_pkg::IDX_MATCH_L))) begin
      temp_q <= wbyte;
    end else if (rd) begin
      case (idx)
        rtcpt_pkg::IDX_COUNT_L: temp_q <= count_value_q[15:8];
        rtcpt_pkg::IDX_TOP_L:   temp_q <= top_sw_q[15:8];
        rtcpt_pkg::IDX_MATCH_L: temp_q <= match_sw_q[15:8];
        default: ;
      endcase
    end
  end

  // R1 count byte pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_pend_q <= rtcpt_pkg::COUNT_RST;
    end else if (wr_count_h) begin
      count_pend_q <= {wbyte, temp_q};
    end
  end

  // R3 top byte pair
  // R5 match byte pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top_sw_q   <= rtcpt_pkg::TOP_RST;
      match_sw_q <= rtcpt_pkg::MATCH_RST;
    end else begin
      if (wr_top_h) top_sw_q <= {wbyte, temp_q};
      if (wr_match_h) match_sw_q <= {wbyte, temp_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slow clock

  logic       osc_prev_q;
  logic       ext_prev_q;
  logic [4:0] div1k_q;
  logic       osc_rise;
  logic       ext_rise;
  logic       slow_tick;

  assign osc_rise = osc32k_in && !osc_prev_q;
  assign ext_rise = ext_clk_in && !ext_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
      div1k_q    <= 5'h00;
    end else begin
      osc_prev_q <= osc32k_in;
      ext_prev_q <= ext_clk_in;
      if (osc_rise) div1k_q <= div1k_q + 5'h01;
    end
  end

  // R14 source select
  always_comb begin
    case (slow_clock_source_q)
      rtcpt_pkg::SRC_32K: slow_tick = osc_rise;
      rtcpt_pkg::SRC_1K:  slow_tick = osc_rise && (div1k_q == rtcpt_pkg::DIV_1K_LAST);
      rtcpt_pkg::SRC_EXT: slow_tick = ext_rise;
      default:            slow_tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisation into the slow domain

  rtcpt_sync_delay u_sync_ctrl (
    .pclk(pclk), .presetn(presetn), .start(wr_ctrl), .slow_tick(slow_tick),
    .busy(ctrl_busy), .apply(ctrl_apply)
  );
  // R2 count sync delay
  rtcpt_sync_delay u_sync_count (
    .pclk(pclk), .presetn(presetn), .start(wr_count_h), .slow_tick(slow_tick),
    .busy(count_sync_pending), .apply(count_apply)
  );
  // R4 top sync delay
  rtcpt_sync_delay u_sync_top (
    .pclk(pclk), .presetn(presetn), .start(wr_top_h), .slow_tick(slow_tick),
    .busy(top_sync_pending), .apply(top_apply)
  );
  rtcpt_sync_delay u_sync_match (
    .pclk(pclk), .presetn(presetn), .start(wr_match_h), .slow_tick(slow_tick),
    .busy(match_busy), .apply(match_apply)
  );
  // R8 control sync pending
  rtcpt_sync_delay u_sync_pit (
    .pclk(pclk), .presetn(presetn), .start(wr_pit), .slow_tick(slow_tick),
    .busy(tick_ctrl_sync_pending), .apply(pit_apply)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_act_q  <= rtcpt_pkg::CTRL_RST;
      pit_act_q   <= rtcpt_pkg::CTRL_RST;
      top_act_q   <= rtcpt_pkg::TOP_RST;
      match_act_q <= rtcpt_pkg::MATCH_RST;
    end else begin
      if (ctrl_apply) ctrl_act_q <= ctrl_sw_q;
      if (pit_apply) pit_act_q <= pit_sw_q;
      if (top_apply) top_act_q <= top_sw_q;
      if (match_apply) match_act_q <= match_sw_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Real-time counter

  logic [14:0] presc_q;
  logic [14:0] presc_mask;
  logic        rtc_run;
  logic        count_tick;
  logic        wrap_set;
  logic        match_set;

  // R11 debug halt choice
  assign rtc_run    = ctrl_act_q.on && (keep_running_when_halted_q || !cpu_debug_halt);
  assign presc_mask = 15'((16'h0001 << ctrl_act_q.code) - 16'h0001);
  // R16 prescaled advance
  assign count_tick = rtc_run && slow_tick && ((presc_q & presc_mask) == presc_mask);
  // R12 wrap at top
  assign wrap_set   = count_tick && !count_apply && (count_value_q == top_act_q);
  // R13 match detect
  assign match_set  = count_tick && !count_apply && (count_value_q == match_act_q);

  // The prescaler restarts from zero whenever the counter is switched off; during a debug halt with the debug bit clear it holds its value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= 15'h0000;
    end else if (!ctrl_act_q.on) begin
      presc_q <= 15'h0000;
    end else if (rtc_run && slow_tick) begin
      presc_q <= presc_q + 15'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_q <= rtcpt_pkg::COUNT_RST;
    end else if (count_apply) begin
      count_value_q <= count_pend_q;
    end else if (count_tick) begin
      count_value_q <= (count_value_q == top_act_q) ? 16'h0000 : count_value_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Periodic tick timer

  logic [14:0] pit_count_q;
  logic [14:0] pit_mask;
  logic        pit_run;
  logic        pit_hit;

  // R11 debug halt choice
  assign pit_run  = pit_act_q.on && (pit_keep_running_q || !cpu_debug_halt);
  assign pit_mask = 15'((16'h0002 << pit_act_q.code) - 16'h0001);
  // R6 interval select
  assign pit_hit  = pit_run && slow_tick && (pit_act_q.code != rtcpt_pkg::PIT_CODE_OFF) &&
                    (pit_act_q.code != rtcpt_pkg::PIT_CODE_RSVD) &&
                    ((pit_count_q & pit_mask) == pit_mask);

  // R16 undivided tick count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pit_count_q <= 15'h0000;
    else if (!pit_act_q.on) pit_count_q <= 15'h0000;
    else if (pit_run && slow_tick) pit_count_q <= pit_count_q + 15'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags and interrupt

  logic [1:0] flag_clr;
  logic       tick_clr;

  assign flag_clr = (wr && (idx == rtcpt_pkg::IDX_INTFLAG)) ? wbyte[1:0] : 2'h0;
  assign tick_clr = wr && (idx == rtcpt_pkg::IDX_PIT_FLAG) && wbyte[0];

  // A set in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q    <= 2'h0;
      tick_irq_q <= 1'b0;
    end else begin
      // R12 wrap flag
      flags_q[rtcpt_pkg::FLAG_WRAP]  <= wrap_set || (flags_q[rtcpt_pkg::FLAG_WRAP] &&
                                                     !flag_clr[rtcpt_pkg::FLAG_WRAP]);
      // R13 match flag
      flags_q[rtcpt_pkg::FLAG_MATCH] <= match_set || (flags_q[rtcpt_pkg::FLAG_MATCH] &&
                                                      !flag_clr[rtcpt_pkg::FLAG_MATCH]);
      // R10 tick flag
      tick_irq_q <= pit_hit || (tick_irq_q && !tick_clr);
    end
  end

  // R9 tick interrupt gate
  assign irq = (|(flags_q & inten_q)) || (tick_irq_q && tick_irq_en_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    case (idx)
      rtcpt_pkg::IDX_CTRL:      rd_val = {1'b0, ctrl_sw_q.code, 2'b00, ctrl_sw_q.on};
      rtcpt_pkg::IDX_STATUS:    rd_val = {4'h0, match_busy, top_sync_pending,
                                          count_sync_pending, ctrl_busy};
      rtcpt_pkg::IDX_INTEN:     rd_val = {6'h00, inten_q};
      rtcpt_pkg::IDX_INTFLAG:   rd_val = {6'h00, flags_q};
      rtcpt_pkg::IDX_TEMP:      rd_val = temp_q;
      rtcpt_pkg::IDX_DBG:       rd_val = {7'h00, keep_running_when_halted_q};
      rtcpt_pkg::IDX_SRC_SEL:   rd_val = {6'h00, slow_clock_source_q};
      rtcpt_pkg::IDX_COUNT_L:   rd_val = count_value_q[7:0];
      rtcpt_pkg::IDX_TOP_L:     rd_val = top_sw_q[7:0];
      rtcpt_pkg::IDX_MATCH_L:   rd_val = match_sw_q[7:0];
      // R15 high byte from latch
      rtcpt_pkg::IDX_COUNT_H,
      rtcpt_pkg::IDX_TOP_H,
      rtcpt_pkg::IDX_MATCH_H:   rd_val = temp_q;
      rtcpt_pkg::IDX_PIT_CTRL:  rd_val = {1'b0, pit_sw_q.code, 2'b00, pit_sw_q.on};
      // R8 control sync pending
      rtcpt_pkg::IDX_PIT_STAT:  rd_val = {7'h00, tick_ctrl_sync_pending};
      rtcpt_pkg::IDX_PIT_IRQEN: rd_val = {7'h00, tick_irq_en_q};
      rtcpt_pkg::IDX_PIT_FLAG:  rd_val = {7'h00, tick_irq_q};
      rtcpt_pkg::IDX_PIT_DBG:   rd_val = {7'h00, pit_keep_running_q};
      default:                  rd_val = 8'h00;
    endcase
  end

  // Read data is captured in the setup cycle so that the access cycle can answer at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= {24'h00_0000, rd_val};
    end
  end

  assign prdata = prdata_q;

endmodule

// ===== rtcpt_sva.sv
`timescale 1ns/100ps

module rtcpt_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        osc32k_in,
  input wire logic        ext_clk_in,
  input wire logic        cpu_debug_halt,
  input wire logic        irq
);
  logic acc;
  logic hole;

  assign acc  = psel && penable;
  // Indices in the gaps of the map must answer with an error, never with stale data.
  assign hole = (paddr[7:2] > 6'h15) || (paddr[7:2] == 6'h06) || (paddr[7:2] == 6'h0E)
             || (paddr[7:2] == 6'h0F) || (paddr[7:2] == 6'h14);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_always: assert property (pready)
    else $error("pready low");
  a_hole_error: assert property (acc && hole |-> pslverr)
    else $error("unmapped access without error");
  a_error_only_hole: assert property (pslverr |-> acc && hole)
    else $error("error on a mapped access or outside access");
  a_hole_reads_zero: assert property (acc && !pwrite && hole |-> prdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_byte_wide_data: assert property (prdata[31:8] == 24'h000000)
    else $error("read data above bit 7");
  a_read_data_hold: assert property (acc |=> $stable(prdata))
    else $error("read data moved after access");
  a_irq_reset_low: assert property ($rose(presetn) |-> !irq)
    else $error("irq high after reset");
  a_irq_has_cause: assert property ($rose(irq) |-> $past(acc && pwrite) || $past(osc32k_in)
      || $past(osc32k_in, 2) || $past(ext_clk_in) || $past(ext_clk_in, 2))
    else $error("irq rose without write or slow tick");

  c_hole: cover property (acc && pslverr);
  c_irq: cover property ($rose(irq));
  c_read: cover property (acc && !pwrite && !hole);
endmodule

bind rtcpt_top rtcpt_sva u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .osc32k_in(osc32k_in), .ext_clk_in(ext_clk_in),
  .cpu_debug_halt(cpu_debug_halt), .irq(irq)
);

// ===== rtc_counter_and_periodic_tick_tb.sv
`timescale 1ns/100ps

module rtc_counter_and_periodic_tick_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        osc32k_in;
  logic        ext_clk_in;
  logic        cpu_debug_halt;
  logic        irq;
  logic [31:0] rd_q;
  logic        err_q;
  logic [7:0]  count0;
  int          num_errors;
  int          cmp_count;
  int          gap;

  localparam logic [5:0] RIDX [11] = '{6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h10,
                                       6'h11, 6'h12, 6'h13, 6'h15};
  localparam logic [7:0] RVAL [11] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00,
                                       8'h00, 8'h00, 8'h00, 8'h00};

  rtcpt_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc32k_in(osc32k_in), .ext_clk_in(ext_clk_in),
    .cpu_debug_halt(cpu_debug_halt), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_q = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      conclude();
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask

  task automatic rc(input string nm, input logic [5:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk(nm, {24'h000000, exp}, rd_q);
  endtask

  task automatic irq_is(input logic exp);
    @(negedge pclk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask

  // Slow cycles are made by hand so that every count below is exact.
  task automatic tk(input int n, input logic ext);
    repeat (n) begin
      @(posedge pclk);
      if (ext) ext_clk_in <= 1'b1;
      else osc32k_in <= 1'b1;
      repeat (2) @(posedge pclk);
      osc32k_in  <= 1'b0;
      ext_clk_in <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask

  // Counts slow cycles until the tick flag shows, then clears it.
  task automatic pgap(input logic ext);
    gap = 0;
    do begin
      tk(1, ext);
      gap++;
      xfer(1'b0, rtcpt_pkg::IDX_PIT_FLAG, 8'h00);
    end while (rd_q[0] !== 1'b1 && gap < 40);
    if (rd_q[0] !== 1'b1) begin
      num_errors++;
      conclude();
    end
    wr(rtcpt_pkg::IDX_PIT_FLAG, 8'h01);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    osc32k_in = 1'b0;
    ext_clk_in = 1'b0;
    cpu_debug_halt = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 11; i++) rc("reset value", RIDX[i], RVAL[i]);
    xfer(1'b0, 6'h0E, 8'h00);
    chk("hole error", 32'h1, {31'h0, err_q});
    chk("hole data", 32'h0, rd_q);
    wr(rtcpt_pkg::IDX_MATCH_L, 8'hC3);
    wr(rtcpt_pkg::IDX_MATCH_H, 8'hA5);
    rc("match low", rtcpt_pkg::IDX_MATCH_L, 8'hC3);
    rc("match high", rtcpt_pkg::IDX_MATCH_H, 8'hA5);
    wr(rtcpt_pkg::IDX_MATCH_L, 8'h05);
    wr(rtcpt_pkg::IDX_MATCH_H, 8'h00);
    wr(rtcpt_pkg::IDX_TOP_L, 8'h07);
    wr(rtcpt_pkg::IDX_TOP_H, 8'h00);
    wr(rtcpt_pkg::IDX_COUNT_L, 8'h03);
    wr(rtcpt_pkg::IDX_COUNT_H, 8'h00);
    rc("sync busy", rtcpt_pkg::IDX_STATUS, 8'h0E);
    rc("count early", rtcpt_pkg::IDX_COUNT_L, 8'h00);
    tk(1, 1'b0);
    rc("busy one tick", rtcpt_pkg::IDX_STATUS, 8'h0E);
    rc("count one tick", rtcpt_pkg::IDX_COUNT_L, 8'h00);
    tk(1, 1'b0);
    rc("busy done", rtcpt_pkg::IDX_STATUS, 8'h00);
    rc("count applied", rtcpt_pkg::IDX_COUNT_L, 8'h03);
    rc("top back", rtcpt_pkg::IDX_TOP_L, 8'h07);
    wr(rtcpt_pkg::IDX_INTEN, 8'h03);
    wr(rtcpt_pkg::IDX_CTRL, 8'h01);
    tk(2, 1'b0);
    xfer(1'b0, rtcpt_pkg::IDX_COUNT_L, 8'h00);
    count0 = rd_q[7:0];
    tk(7 - int'(count0), 1'b0);
    rc("count at top", rtcpt_pkg::IDX_COUNT_L, 8'h07);
    rc("match flag", rtcpt_pkg::IDX_INTFLAG, 8'h02);
    tk(1, 1'b0);
    rc("count wrapped", rtcpt_pkg::IDX_COUNT_L, 8'h00);
    rc("wrap flag", rtcpt_pkg::IDX_INTFLAG, 8'h03);
    irq_is(1'b1);
    wr(rtcpt_pkg::IDX_INTEN, 8'h00);
    irq_is(1'b0);
    wr(rtcpt_pkg::IDX_INTFLAG, 8'h03);
    rc("flags cleared", rtcpt_pkg::IDX_INTFLAG, 8'h00);
    wr(rtcpt_pkg::IDX_CTRL, 8'h00);
    tk(2, 1'b0);
    wr(rtcpt_pkg::IDX_PIT_IRQEN, 8'h01);
    for (int c = 1; c < 4; c++) begin
      wr(rtcpt_pkg::IDX_PIT_CTRL, {1'b0, 4'(c), 3'b001});
      rc("tick busy", rtcpt_pkg::IDX_PIT_STAT, 8'h01);
      tk(2, 1'b0);
      rc("tick idle", rtcpt_pkg::IDX_PIT_STAT, 8'h00);
      rc("tick ctrl", rtcpt_pkg::IDX_PIT_CTRL, {1'b0, 4'(c), 3'b001});
      pgap(1'b0);
      pgap(1'b0);
      chk("tick spacing", 32'(1 << (c + 1)), 32'(gap));
    end
    tk(16, 1'b0);
    irq_is(1'b1);
    wr(rtcpt_pkg::IDX_PIT_IRQEN, 8'h00);
    irq_is(1'b0);
    wr(rtcpt_pkg::IDX_PIT_FLAG, 8'h01);
    rc("tick flag clear", rtcpt_pkg::IDX_PIT_FLAG, 8'h00);
    foreach (RVAL[k]) begin
      if (k < 2) begin
        wr(rtcpt_pkg::IDX_PIT_CTRL, (k == 0) ? 8'h01 : 8'h79);
        tk(2, 1'b0);
        wr(rtcpt_pkg::IDX_PIT_FLAG, 8'h01);
        tk(20, 1'b0);
        rc("no tick code", rtcpt_pkg::IDX_PIT_FLAG, 8'h00);
      end
    end
    wr(rtcpt_pkg::IDX_PIT_CTRL, 8'h09);
    tk(2, 1'b0);
    cpu_debug_halt <= 1'b1;
    wr(rtcpt_pkg::IDX_PIT_FLAG, 8'h01);
    tk(12, 1'b0);
    rc("halted", rtcpt_pkg::IDX_PIT_FLAG, 8'h00);
    wr(rtcpt_pkg::IDX_PIT_DBG, 8'h01);
    tk(8, 1'b0);
    rc("debug run", rtcpt_pkg::IDX_PIT_FLAG, 8'h01);
    cpu_debug_halt <= 1'b0;
    wr(rtcpt_pkg::IDX_SRC_SEL, 8'h03);
    wr(rtcpt_pkg::IDX_PIT_FLAG, 8'h01);
    tk(12, 1'b0);
    rc("ext ignores osc", rtcpt_pkg::IDX_PIT_FLAG, 8'h00);
    tk(8, 1'b1);
    rc("ext ticks", rtcpt_pkg::IDX_PIT_FLAG, 8'h01);
    wr(rtcpt_pkg::IDX_SRC_SEL, 8'h02);
    wr(rtcpt_pkg::IDX_PIT_FLAG, 8'h01);
    tk(8, 1'b0);
    tk(8, 1'b1);
    rc("no source", rtcpt_pkg::IDX_PIT_FLAG, 8'h00);
    wr(rtcpt_pkg::IDX_SRC_SEL, 8'h01);
    wr(rtcpt_pkg::IDX_PIT_FLAG, 8'h01);
    tk(12, 1'b0);
    rc("divided slow", rtcpt_pkg::IDX_PIT_FLAG, 8'h00);
    tk(140, 1'b0);
    rc("divided tick", rtcpt_pkg::IDX_PIT_FLAG, 8'h01);
    wr(rtcpt_pkg::IDX_SRC_SEL, 8'h00);
    wr(rtcpt_pkg::IDX_CTRL, 8'h11);
    tk(2, 1'b0);
    xfer(1'b0, rtcpt_pkg::IDX_COUNT_L, 8'h00);
    count0 = rd_q[7:0];
    tk(3, 1'b0);
    rc("prescaled hold", rtcpt_pkg::IDX_COUNT_L, count0);
    tk(1, 1'b0);
    rc("prescaled step", rtcpt_pkg::IDX_COUNT_L, count0 + 8'h01);
    cpu_debug_halt <= 1'b1;
    tk(4, 1'b0);
    rc("count halted", rtcpt_pkg::IDX_COUNT_L, count0 + 8'h01);
    wr(rtcpt_pkg::IDX_DBG, 8'h01);
    tk(4, 1'b0);
    rc("count debug run", rtcpt_pkg::IDX_COUNT_L, count0 + 8'h02);
    conclude();
  end
endmodule
